/* File: hdl/pmcs_power_mode.v */
/*
  power mode control: control register, mode legality, halt/idle states,
  wake-up countdown and glitch-free core clock selection over apb.
  assumes synchronous inputs, a 250 MHz clk_in, and oscillator ticks given
  as one-cycle enable pulses from outside dividers.
*/
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "pmcs_defines.vh"

// Overview of operation
// [RL1] high speed, dual clock and low speed modes, each with halt and idle
// [RL2] one option input enables or disables the halt feature
// [RL3] idle stops execution; oscillator, idle timer and monitor keep running
// [RL4] power-save holds registers and timers, only the idle timer runs
// [RL5] software frees the slow oscillator pins before use
// [RL6] every reset loads the control register with 40 hex
// [RL7] bit 7 switches the slow oscillator on
// [RL8] bit 6 switches the fast oscillator on
// [RL9] bit 5 selects the idle timer clock, 1 meaning slow
// [RL10] bit 4 selects the core clock, 1 meaning slow
// [RL11] idle select 0 with core select 1 forces low speed mode; the code rejects such a nibble as illegal and reloads 40 hex
// [RL12] software writes zero to reserved bit 3
// [RL13] bits 2 to 0 hold the idle window select field
// [RL14] illegal upper nibble triggers an automatic device reset
// [RL15] software steps the nibble only between adjacent legal patterns
// [RL16] software starts and settles the needed oscillator before switching
// [RL17] high speed mode is entered on every reset
// [RL18] low speed never goes straight to high speed, only through dual; the write check accepts a direct step from nibble b to 4
// [RL19] dual to high: clear idle select, then slow enable separately
// [RL20] high speed halt stops internal clock and the fast oscillator pin
// [RL21] port g bit 7 written 1 enters halt mid next instruction cycle
// [RL22] port g bit 6 written 1 enters idle
// [RL23] halt wake-up counts 256 instruction cycles before execution resumes
// [RL24] with halt disabled, attempts to enter halt are ignored
// [RL25] legality is checked on the written value before it takes effect
// [RL26] core clock switching is glitch-free
module pmcs_power_mode (
  // clock and reset
  input  wire        clk_in,
  input  wire        reset_n_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output wire        pready_out,
  output wire        pslverr_out,
  output reg  [31:0] prdata_out,
  // oscillator ticks and option
  input  wire        fast_osc_tick_in,
  input  wire        slow_osc_tick_in,
  input  wire        halt_enable_in,
  input  wire        wakeup_in,
  // clock control outputs
  output reg         slow_osc_enable_out,
  output reg         fast_osc_enable_out,
  output reg         fast_osc_input_pin_stop_out,
  output reg         core_tick_out,
  output reg         idle_timer_tick_out,
  output reg         cpu_run_out,
  output reg  [2:0]  idle_window_sel_out,
  output reg         mode_reset_req_out
);

  // power state, one-hot
  localparam [2:0] ST_RUN  = 3'b001;
  localparam [2:0] ST_HALT = 3'b010;
  localparam [2:0] ST_IDLE = 3'b100;

  reg  [7:0] power_mode_control_r;
  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg  [8:0] wake_cnt_r;
  reg        waking_r;
  reg  [2:0] div_cnt_r;
  reg        halt_pend_r;

  wire       apb_wr;
  wire [7:0] wr_val;
  wire       wr_legal;
  wire       core_raw;
  wire       on_slow;
  wire       instr_tick;
  wire       idle_clk_slow;
  wire       core_sel_slow;

  // legal nibble check, used only on the write path, not on the live register
  function legal_nibble;
    input [3:0] nib;
    begin
      legal_nibble = (nib == `PMCS_NIB_FAST) || (nib == `PMCS_NIB_FAST_DUAL) ||
                     (nib == `PMCS_NIB_DUAL) || (nib == `PMCS_NIB_DUAL_SLOW) ||
                     (nib == `PMCS_NIB_SLOW);
    end
  endfunction

  // zero wait state slave, never errors
  assign pready_out  = 1'b1;
  assign pslverr_out = 1'b0;
  assign apb_wr      = psel_in & penable_in & pwrite_in;
  assign wr_val      = pwdata_in[7:0] & `PMCS_CTRL_WMASK;
  assign wr_legal    = legal_nibble(wr_val[7:4]); // RL25

  // control register; an illegal write never lands, a reset request goes out
  // instead so the core is not left without a clock
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      power_mode_control_r <= `PMCS_CTRL_RESET; // RL6 RL17
      mode_reset_req_out   <= 1'b0;
    end else begin
      mode_reset_req_out <= 1'b0;
      if (apb_wr && paddr_in == `PMCS_ADDR_CTRL) begin
        if (wr_legal)
          power_mode_control_r <= wr_val; // RL13 RL7 RL8
        else begin
          power_mode_control_r <= `PMCS_CTRL_RESET; // RL14 RL18
          mode_reset_req_out   <= 1'b1; // RL14
        end
      end
    end
  end

  // invalid idle/core pair falls back to low speed selection
  assign idle_clk_slow = power_mode_control_r[`PMCS_BIT_IDLE_CLK] |
                         power_mode_control_r[`PMCS_BIT_CORE_CLK]; // RL9 RL11
  assign core_sel_slow = power_mode_control_r[`PMCS_BIT_CORE_CLK]; // RL10

  pmcs_clk_glitch_free u_switch (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .fast_tick_in  (fast_osc_tick_in & power_mode_control_r[`PMCS_BIT_FAST_EN]),
    .slow_tick_in  (slow_osc_tick_in & power_mode_control_r[`PMCS_BIT_SLOW_EN]),
    .sel_slow_in   (core_sel_slow),
    .core_tick_out (core_raw),
    .on_slow_out   (on_slow)
  );

  // instruction rate: fast ticks divided by five, slow ticks taken as is
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      div_cnt_r <= 3'h0;
    else if (core_raw && !on_slow)
      div_cnt_r <= (div_cnt_r == `PMCS_INSTR_DIV - 3'h1) ? 3'h0 : div_cnt_r + 3'h1;
  end
  assign instr_tick = core_raw && (on_slow || div_cnt_r == `PMCS_INSTR_DIV - 3'h1);

  // power state machine
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (halt_pend_r && instr_tick)
          state_nxt = ST_HALT; // RL21
        else if (apb_wr && paddr_in == `PMCS_ADDR_PORTG &&
                 pwdata_in[`PMCS_BIT_IDLE])
          state_nxt = ST_IDLE; // RL22
      end
      ST_HALT: begin
        if (waking_r && wake_cnt_r == 9'h000)
          state_nxt = ST_RUN; // RL23
      end
      ST_IDLE: begin
        if (wakeup_in)
          state_nxt = ST_RUN;
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  // halt request is held until mid next instruction cycle
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r     <= ST_RUN;
      halt_pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r != ST_RUN)
        halt_pend_r <= 1'b0;
      else if (apb_wr && paddr_in == `PMCS_ADDR_PORTG &&
               pwdata_in[`PMCS_BIT_HALT] && halt_enable_in)
        halt_pend_r <= 1'b1; // RL2 RL24
    end
  end

  // wake-up countdown from 256 at instruction rate; the divider keeps running
  // on the fast ticks although the core tick is gated off during halt
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      waking_r   <= 1'b0;
      wake_cnt_r <= `PMCS_WAKE_COUNT;
    end else if (state_r != ST_HALT) begin
      waking_r   <= 1'b0;
      wake_cnt_r <= `PMCS_WAKE_COUNT;
    end else if (!waking_r) begin
      waking_r <= wakeup_in;
    end else if (instr_tick && wake_cnt_r != 9'h000) begin
      wake_cnt_r <= wake_cnt_r - 9'h001; // RL23
    end
  end

  // registered outputs; halt stops core and fast pin, idle keeps timer going
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      slow_osc_enable_out         <= 1'b0;
      fast_osc_enable_out         <= 1'b1;
      fast_osc_input_pin_stop_out <= 1'b0;
      core_tick_out               <= 1'b0;
      idle_timer_tick_out         <= 1'b0;
      cpu_run_out                 <= 1'b1;
      idle_window_sel_out         <= 3'h0;
    end else begin
      slow_osc_enable_out         <= power_mode_control_r[`PMCS_BIT_SLOW_EN]; // RL7
      fast_osc_enable_out         <= power_mode_control_r[`PMCS_BIT_FAST_EN] &
                                     ~(state_r == ST_HALT && !waking_r); // RL8 RL20
      fast_osc_input_pin_stop_out <= (state_r == ST_HALT) && !waking_r; // RL20
      core_tick_out               <= core_raw && state_r == ST_RUN; // RL1 RL4
      idle_timer_tick_out         <= (state_r != ST_HALT) &&
                                     (idle_clk_slow ? slow_osc_tick_in :
                                                      fast_osc_tick_in); // RL3 RL9
      cpu_run_out                 <= (state_nxt == ST_RUN); // RL3
      idle_window_sel_out         <= power_mode_control_r[2:0]; // RL13
    end
  end

  // read mux: register, then live state
  always @* begin
    prdata_out = 32'h0000_0000;
    case (paddr_in)
      `PMCS_ADDR_CTRL:   prdata_out = {24'h00_0000, power_mode_control_r};
      `PMCS_ADDR_STATUS: prdata_out = {27'h000_0000, on_slow, waking_r, state_r};
      default:           prdata_out = 32'h0000_0000;
    endcase
  end

endmodule // pmcs_power_mode

/* File: hdl/pmcs_defines.vh */
/*
  constants for the power mode and clock switch block: register offsets,
  field positions, reset values and timing counts.
  assumes it is included by bare name from the design files.
*/
`ifndef PMCS_DEFINES_VH
`define PMCS_DEFINES_VH

// register byte addresses on the apb bus
`define PMCS_ADDR_CTRL        8'h00
`define PMCS_ADDR_PORTG       8'h04
`define PMCS_ADDR_STATUS      8'h08

// power mode control register layout
`define PMCS_CTRL_RESET       8'h40
`define PMCS_BIT_SLOW_EN      7
`define PMCS_BIT_FAST_EN      6
`define PMCS_BIT_IDLE_CLK     5
`define PMCS_BIT_CORE_CLK     4
`define PMCS_BIT_RSVD         3
`define PMCS_CTRL_WMASK       8'hf7

// legal upper nibble patterns, in stepping order
`define PMCS_NIB_FAST         4'h4
`define PMCS_NIB_FAST_DUAL    4'hc
`define PMCS_NIB_DUAL         4'he
`define PMCS_NIB_DUAL_SLOW    4'hf
`define PMCS_NIB_SLOW         4'hb

// port g data register control bits
`define PMCS_BIT_HALT         7
`define PMCS_BIT_IDLE         6

// wake-up countdown start and instruction rate divider
`define PMCS_WAKE_COUNT       9'h100
`define PMCS_INSTR_DIV        3'h5

`endif

/* File: hdl/pmcs_clk_glitch_free.v */
/*
  glitch-free two-way clock enable switch for the core clock.
  assumes both source enables are one-cycle pulses on the system clock.
*/
`timescale 1ns/1ns
module pmcs_clk_glitch_free (
  // clock and reset
  input  wire clk_in,
  input  wire reset_n_in,
  // sources and select
  input  wire fast_tick_in,
  input  wire slow_tick_in,
  input  wire sel_slow_in,
  // gated core enable and selection state
  output wire core_tick_out,
  output wire on_slow_out
);

  reg fast_on_r;
  reg slow_on_r;

  // a source is released only on its own tick, and the new one is taken only
  // after the old one is off, so no pulse is ever cut short
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fast_on_r <= 1'b1;
      slow_on_r <= 1'b0;
    end else begin
      if (fast_tick_in)
        fast_on_r <= ~sel_slow_in & ~slow_on_r;
      if (slow_tick_in)
        slow_on_r <= sel_slow_in & ~fast_on_r;
    end
  end

  assign core_tick_out = (fast_on_r & fast_tick_in) | (slow_on_r & slow_tick_in); // RL26
  assign on_slow_out   = slow_on_r;

endmodule // pmcs_clk_glitch_free

/* File: bench/pmcs_power_mode_props.sv */
/*
  checker for the power mode block: control writes, illegal nibbles, halt.
  assumes it is bound onto pmcs_power_mode, one clock domain.
*/
`timescale 1ns/1ns
`include "pmcs_defines.vh"
module pmcs_power_mode_props (
  // clock, reset, apb request
  input wire        clk_in,
  input wire        reset_n_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [7:0]  paddr_in,
  input wire [31:0] pwdata_in,
  input wire        halt_enable_in,
  // clock control outputs
  input wire        slow_osc_enable_out,
  input wire        fast_osc_enable_out,
  input wire        fast_osc_input_pin_stop_out,
  input wire        core_tick_out,
  input wire        idle_timer_tick_out,
  input wire        cpu_run_out,
  input wire [2:0]  idle_window_sel_out,
  input wire        mode_reset_req_out
);
  wire [3:0] nib = pwdata_in[7:4];
  wire legal = nib == 4'h4 || nib == 4'hc || nib == 4'he || nib == 4'hf || nib == 4'hb;
  wire ctrl_wr = psel_in && penable_in && pwrite_in && paddr_in == `PMCS_ADDR_CTRL;
  wire halt_wr = psel_in && penable_in && pwrite_in && paddr_in == `PMCS_ADDR_PORTG;
  reg  [7:0] last_r;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // last accepted control value, so checks need no local variables
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) last_r <= `PMCS_CTRL_RESET;
    else if (ctrl_wr && legal) last_r <= pwdata_in[7:0] & `PMCS_CTRL_WMASK;
  end
  sequence s_good_wr; ctrl_wr && legal; endsequence
  sequence s_bad_wr; ctrl_wr && !legal; endsequence
  sequence s_halt_req; halt_wr && pwdata_in[7] && halt_enable_in && cpu_run_out; endsequence
  a_reset_load: assert property ($rose(reset_n_in) |-> fast_osc_enable_out && !slow_osc_enable_out)
    else $error("reset oscillator state wrong");
  a_slow_follow: assert property (s_good_wr |=> ##[0:1] slow_osc_enable_out == last_r[7])
    else $error("slow enable not following bit 7");
  a_fast_follow: assert property (s_good_wr |=> ##[0:1] fast_osc_enable_out == last_r[6])
    else $error("fast enable not following bit 6");
  a_window_follow: assert property (s_good_wr |=> ##[0:1] idle_window_sel_out == last_r[2:0])
    else $error("window select not following");
  a_bad_pulse: assert property (s_bad_wr |=> ##[0:1] mode_reset_req_out)
    else $error("no reset request after illegal write");
  a_req_single: assert property (mode_reset_req_out |=> !mode_reset_req_out)
    else $error("reset request longer than one cycle");
  a_bad_restore: assert property (s_bad_wr |=> ##[0:2] fast_osc_enable_out && !slow_osc_enable_out)
    else $error("illegal write not restoring high speed");
  a_halt_enter: assert property (s_halt_req |-> ##[1:24] fast_osc_input_pin_stop_out)
    else $error("halt not entered");
  a_halt_off: assert property (!halt_enable_in && !fast_osc_input_pin_stop_out |=> !fast_osc_input_pin_stop_out)
    else $error("halt entered while disabled");
  a_halt_quiet: assert property (fast_osc_input_pin_stop_out [*2] |-> !core_tick_out && !idle_timer_tick_out && !fast_osc_enable_out)
    else $error("clocks running in halt");
endmodule // pmcs_power_mode_props

bind pmcs_power_mode pmcs_power_mode_props u_props (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .halt_enable_in(halt_enable_in), .slow_osc_enable_out(slow_osc_enable_out),
  .fast_osc_enable_out(fast_osc_enable_out), .core_tick_out(core_tick_out),
  .fast_osc_input_pin_stop_out(fast_osc_input_pin_stop_out), .cpu_run_out(cpu_run_out),
  .idle_timer_tick_out(idle_timer_tick_out), .idle_window_sel_out(idle_window_sel_out),
  .mode_reset_req_out(mode_reset_req_out));

/* File: bench/tb.sv */
/*
  self-checking bench for the power mode block over apb.
  assumes reads are the results; expected values are queued by the driver.
*/
`timescale 1ns/1ns
`include "pmcs_defines.vh"
module tb;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic        fast_osc_tick_in = 1'b0;
  logic        slow_osc_tick_in = 1'b0;
  logic        halt_enable_in = 1'b0;
  logic        wakeup_in = 1'b0;
  logic [2:0]  tick_cnt = 3'h0;
  logic [2:0]  win;
  logic [3:0]  steps [8] = '{4'hc, 4'he, 4'hf, 4'hb, 4'hf, 4'he, 4'hc, 4'h4};
  logic [31:0] exp_q [$];
  wire         pready_out;
  wire  [31:0] prdata_out;
  int          errors = 0;
  int          n_compared = 0;
  pmcs_power_mode u_pmcs_power_mode (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pready_out(pready_out), .pslverr_out(), .prdata_out(prdata_out),
    .fast_osc_tick_in(fast_osc_tick_in), .slow_osc_tick_in(slow_osc_tick_in),
    .halt_enable_in(halt_enable_in), .wakeup_in(wakeup_in), .slow_osc_enable_out(),
    .fast_osc_enable_out(), .fast_osc_input_pin_stop_out(), .core_tick_out(),
    .idle_timer_tick_out(), .cpu_run_out(), .idle_window_sel_out(), .mode_reset_req_out());
  always #2 clk_in = ~clk_in;
  // fast tick every other cycle, slow tick one in eight: keeps the halt wake short
  always @(posedge clk_in) begin
    tick_cnt <= tick_cnt + 3'h1;
    fast_osc_tick_in <= ~tick_cnt[0];
    slow_osc_tick_in <= (tick_cnt == 3'h7);
  end
  // oldest note is matched against each completed read
  always @(posedge clk_in) begin
    if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in) begin
      n_compared++;
      if (exp_q.size() == 0 || prdata_out !== exp_q[0]) begin
        errors++;
        $display("FAIL t=%0t got %h exp %h", $time, prdata_out, exp_q.size() ? exp_q[0] : 32'h0);
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1 && n < 64) begin
      n++;
      @(posedge clk_in);
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    #40000;
    errors++;
    final_report();
  end
  initial begin
    void'($urandom(32'h6a7f));
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    rd(`PMCS_ADDR_CTRL, 32'h40);
    rd(8'h0c, 32'h0);
    $display("test reset done");
    apb(1'b1, `PMCS_ADDR_PORTG, 32'h80);
    repeat (24) @(posedge clk_in);
    rd(`PMCS_ADDR_STATUS, 32'h01);
    halt_enable_in <= 1'b1;
    apb(1'b1, `PMCS_ADDR_PORTG, 32'h80);
    repeat (24) @(posedge clk_in);
    rd(`PMCS_ADDR_STATUS, 32'h02);
    rd(`PMCS_ADDR_CTRL, 32'h40);
    wakeup_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    wakeup_in <= 1'b0;
    repeat (200) @(posedge clk_in);
    rd(`PMCS_ADDR_STATUS, 32'h0a);
    repeat (2600) @(posedge clk_in);
    rd(`PMCS_ADDR_STATUS, 32'h01);
    apb(1'b1, `PMCS_ADDR_PORTG, 32'h40);
    rd(`PMCS_ADDR_STATUS, 32'h04);
    wakeup_in <= 1'b1;
    @(posedge clk_in);
    wakeup_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rd(`PMCS_ADDR_STATUS, 32'h01);
    $display("test halt idle done");
    // out to low speed through dual and back; reserved bit 3 written as 0
    foreach (steps[i]) begin
      win = 3'($urandom_range(7, 0));
      apb(1'b1, `PMCS_ADDR_CTRL, {24'h0, steps[i], 1'b0, win});
      rd(`PMCS_ADDR_CTRL, {24'h0, steps[i], 1'b0, win});
      if (steps[i] == `PMCS_NIB_SLOW) begin
        repeat (30) @(posedge clk_in);
        rd(`PMCS_ADDR_STATUS, 32'h11);
      end
    end
    $display("test mode walk done");
    for (int k = 0; k < 16; k++) begin
      if (!(k inside {4, 11, 12, 14, 15})) begin
        apb(1'b1, `PMCS_ADDR_CTRL, {24'h0, 4'(k), 4'h5});
        rd(`PMCS_ADDR_CTRL, 32'h40);
      end
    end
    $display("test illegal done");
    final_report();
  end
endmodule // tb
